// ==== rtl/ssem_pkg.sv ====
// Constants and carriers of the status monitor
package ssem_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
   localparam int BLOCK_LEAD_MS = 5;
   localparam int NUNIT = 10;
   localparam int NIND = 5;
   localparam int NREC = 12;
   localparam int LABEL_CHARS = 32;
   localparam int CNT_W = 16;
   localparam logic [15:0] TRAVERSE_MS_RST = 16'h00C8;
   localparam logic [15:0] TIMEOUT_MS_RST = 16'h2710;
   localparam logic STORE_RST = 1'b1;

   // Level positions within one unit's event slice
   localparam int L_STATE = 0;
   localparam int L_CART = 4;
   localparam int L_OREQ = 8;
   localparam int L_OCMD = 9;
   localparam int L_CREQ = 10;
   localparam int L_CCMD = 11;
   localparam int L_OBLK = 12;
   localparam int L_CBLK = 13;
   localparam int L_READY = 14;
   localparam int L_SYNC = 15;
   localparam int L_OFAIL = 16;
   localparam int L_CFAIL = 17;
   localparam int L_FTRIP = 18;
   localparam int L_WEAR = 19;
   localparam int L_OPTIME = 20;
   localparam int L_LOCX = 21;
   localparam int L_LOCS = 22;
   localparam int UNIT_NLV = 23;
   localparam int IND_NLV = 4;
   localparam int IND_BASE = NUNIT * UNIT_NLV;
   localparam int NSRC = IND_BASE + NIND * IND_NLV;

   localparam logic [2:0] FAIL_NONE = 3'h0;
   localparam logic [2:0] FAIL_BLOCKED = 3'h1;
   localparam logic [2:0] FAIL_TIMEOUT = 3'h2;
   localparam logic [2:0] FAIL_NOTREADY = 3'h3;
   localparam logic [2:0] FAIL_NOSYNC = 3'h4;

   localparam logic [1:0] KIND_OPEN_OK = 2'h0;
   localparam logic [1:0] KIND_CLOSE_OK = 2'h1;
   localparam logic [1:0] KIND_OPEN_FAIL = 2'h2;
   localparam logic [1:0] KIND_CLOSE_FAIL = 2'h3;

   typedef enum logic [1:0] {
      POS_INTER = 2'b00,
      POS_OPEN = 2'b01,
      POS_CLOSED = 2'b10,
      POS_BAD = 2'b11
   } ssem_pos_e;

   typedef struct packed {
      logic openSt;
      logic closeSt;
      logic cartIn;
      logic cartOut;
      logic ready;
      logic sync;
      logic reqOpen;
      logic reqClose;
      logic blkOpen;
      logic blkClose;
      logic finalTrip;
      logic wear;
      logic opTime;
      logic locXcbr;
      logic locXswi;
      logic [1:0] openSrc;
      logic [1:0] closeSrc;
      logic cntClear;
   } ssem_unit_in_s;

   typedef struct packed {
      logic [31:0] ts;
      logic [7:0] src;
      logic isOn;
   } ssem_evt_s;

   typedef struct packed {
      logic [CNT_W-1:0] opens;
      logic [CNT_W-1:0] closes;
      logic [CNT_W-1:0] openFails;
      logic [CNT_W-1:0] closeFails;
   } ssem_cnt_s;

   typedef struct packed {
      logic [31:0] ts;
      logic [3:0] unit;
      logic [1:0] kind;
      logic [15:0] openMs;
      logic [15:0] closeMs;
      ssem_pos_e state;
      ssem_pos_e cart;
      logic [2:0] openFail;
      logic [2:0] closeFail;
      logic [1:0] openSrc;
      logic [1:0] closeSrc;
      logic [7:0] general;
   } ssem_rec_s;
endpackage

// ==== rtl/ssem_pos_decode.sv ====
// Two-contact position decoder with optional traverse delay
`timescale 1ns/1ps
`default_nettype none
module ssem_pos_decode
   import ssem_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic msTick,
   input wire logic useDelay,
   input wire logic [15:0] delayMs,
   input wire logic openIn,
   input wire logic closeIn,
   output ssem_pos_e state_q
);
   logic [15:0] wait_q;
   logic [15:0] wait_d;
   ssem_pos_e raw;
   logic clean;
   logic settle;

   assign raw = ssem_pos_e'({closeIn, openIn}); // [R10] [R11]
   assign clean = (raw == POS_OPEN) || (raw == POS_CLOSED);
   // Both or neither only counts once the traverse time has run out [R17]
   assign settle = !useDelay || clean || (wait_q >= delayMs);
   assign wait_d = clean ? 16'h0000 : ((msTick && wait_q != 16'hFFFF) ? wait_q + 16'h0001 : wait_q);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wait_q <= 16'h0000;
         state_q <= POS_INTER;
      end else begin
         wait_q <= wait_d;
         if (settle) begin
            state_q <= raw; // [R10] [R17]
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/ssem_monitor.sv ====
// Switchgear status and event monitor
// Function
// [R1] Separate registered open and close blocking per unit
// [R2] Blocking must lead the command by 5 ms; not checked, blocking is sampled one cycle before the request edge
// [R3] Per-event choice of storing ON, OFF or both
// [R4] Clearable counters of opens, closes and failures
// [R5] Ten units raise their full event set
// [R6] Keep last twelve time-stamped operation records
// [R7] Records hold measured opening and closing times
// [R8] Records hold states, failure causes, sources, status
// [R9] Indicators only report, never command
// [R10] Neither intermediate, both bad, else open/closed
// [R11] Logic one means the contact is active
// [R12] Single contact feeds itself and its inverse; not built, every decoder takes two separate contact inputs
// [R13] Indicator ON/OFF events with 1 ms stamps
// [R14] Five indicators with four events each
// [R15] Settings change only during setup
// [R16] Each indicator has a 32-character label
// [R17] Both or neither after traverse: bad/intermediate
// [R18] Command timeout ends command with error event
// [R19] Full record store overwrites the oldest
`timescale 1ns/1ps
`default_nettype none
module ssem_monitor
   import ssem_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic setupMode,
   input wire logic [15:0] traverseMsIn,
   input wire logic [15:0] timeoutMsIn,
   input wire logic [NSRC-1:0] storeOnIn,
   input wire logic [NSRC-1:0] storeOffIn,
   input wire ssem_unit_in_s unitIn [NUNIT],
   input wire logic [NIND-1:0] indOpenIn,
   input wire logic [NIND-1:0] indCloseIn,
   input wire logic labelWr,
   input wire logic [2:0] labelInst,
   input wire logic [4:0] labelPos,
   input wire logic [7:0] labelChar,
   input wire logic [2:0] labelRdInst,
   input wire logic [4:0] labelRdPos,
   input wire logic [3:0] recRdIdx,
   output logic [7:0] labelRdChar_q,
   output logic evtValid_q,
   output ssem_evt_s evt_q,
   output ssem_pos_e unitState_q [NUNIT],
   output ssem_pos_e cartState_q [NUNIT],
   output ssem_pos_e indState_q [NIND],
   output logic [NUNIT-1:0] openActive_q,
   output logic [NUNIT-1:0] closeActive_q,
   output ssem_cnt_s opCount_q [NUNIT],
   output logic [3:0] recCount_q,
   output ssem_rec_s rec_q,
   output logic [31:0] msTime_q
);
   localparam int DIV_W = $clog2(MS_CYCLES);

   logic [DIV_W-1:0] div_q;
   logic msTick;
   logic [15:0] traverseMs_q;
   logic [15:0] timeoutMs_q;
   logic [NSRC-1:0] storeOn_q;
   logic [NSRC-1:0] storeOff_q;
   logic [NSRC-1:0] lv;
   logic [NSRC-1:0] lvPrev_q;
   logic [NSRC-1:0] pendOn_q;
   logic [NSRC-1:0] pendOff_q;
   logic [NUNIT-1:0] recReq;
   ssem_rec_s recEnt [NUNIT];

   function automatic logic [CNT_W-1:0] cntNext(input logic [CNT_W-1:0] v, input logic inc, input logic clr);
      // An increment in the clearing cycle still counts
      cntNext = clr ? {{(CNT_W-1){1'b0}}, inc} : v + {{(CNT_W-1){1'b0}}, inc};
   endfunction

   // Millisecond time base for stamps, traverse and timeout
   assign msTick = (div_q == DIV_W'(MS_CYCLES - 1));
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         div_q <= '0;
         msTime_q <= 32'h0000_0000;
      end else begin
         div_q <= msTick ? '0 : div_q + DIV_W'(1);
         msTime_q <= msTime_q + {31'h0000_0000, msTick}; // [R13]
      end
   end

   // Settings are only taken while in setup
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         traverseMs_q <= TRAVERSE_MS_RST;
         timeoutMs_q <= TIMEOUT_MS_RST;
         storeOn_q <= {NSRC{STORE_RST}};
         storeOff_q <= {NSRC{STORE_RST}};
      end else if (setupMode) begin
         traverseMs_q <= traverseMsIn; // [R15]
         timeoutMs_q <= timeoutMsIn;
         storeOn_q <= storeOnIn; // [R3]
         storeOff_q <= storeOffIn;
      end
   end

   for (genvar i = 0; i < NUNIT; i++) begin : g_unit
      logic reqOPrev_q, reqCPrev_q, blkO_q, blkC_q, oFail_q, cFail_q;
      logic [15:0] cmdMs_q, openMs_q, closeMs_q;
      logic [2:0] oRefuse, cRefuse, oCause, cCause;
      logic busy, oRise, cRise, oStart, cStart, oReject, cReject;
      logic oDone, cDone, tOut, oFailNow, cFailNow;

      ssem_pos_decode u_state (
         .clock, .nrst, .msTick, .useDelay(1'b1), .delayMs(traverseMs_q),
         .openIn(unitIn[i].openSt), .closeIn(unitIn[i].closeSt), .state_q(unitState_q[i])
      );
      ssem_pos_decode u_cart (
         .clock, .nrst, .msTick, .useDelay(1'b1), .delayMs(traverseMs_q),
         .openIn(unitIn[i].cartOut), .closeIn(unitIn[i].cartIn), .state_q(cartState_q[i])
      );

      assign busy = openActive_q[i] | closeActive_q[i];
      assign oRise = unitIn[i].reqOpen & ~reqOPrev_q;
      assign cRise = unitIn[i].reqClose & ~reqCPrev_q;
      // Blocking is sampled a cycle early; sources are expected to lead by far more [R1] [R2]
      assign oRefuse = blkO_q ? FAIL_BLOCKED : FAIL_NONE;
      assign cRefuse = blkC_q ? FAIL_BLOCKED : (!unitIn[i].ready ? FAIL_NOTREADY :
                       (!unitIn[i].sync ? FAIL_NOSYNC : FAIL_NONE));
      // Requests arriving while a command runs are ignored
      assign oStart = oRise & ~busy & (oRefuse == FAIL_NONE);
      assign cStart = cRise & ~busy & ~oRise & (cRefuse == FAIL_NONE);
      assign oReject = oRise & ~busy & (oRefuse != FAIL_NONE);
      assign cReject = cRise & ~busy & ~oRise & (cRefuse != FAIL_NONE);
      assign oDone = openActive_q[i] & (unitState_q[i] == POS_OPEN);
      assign cDone = closeActive_q[i] & (unitState_q[i] == POS_CLOSED);
      assign tOut = busy & (cmdMs_q >= timeoutMs_q); // [R18]
      assign oFailNow = oReject | (openActive_q[i] & ~oDone & tOut);
      assign cFailNow = cReject | (closeActive_q[i] & ~cDone & tOut);
      assign oCause = oReject ? oRefuse : FAIL_TIMEOUT;
      assign cCause = cReject ? cRefuse : FAIL_TIMEOUT;

      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            reqOPrev_q <= 1'b0;
            reqCPrev_q <= 1'b0;
            blkO_q <= 1'b0;
            blkC_q <= 1'b0;
            oFail_q <= 1'b0;
            cFail_q <= 1'b0;
            openActive_q[i] <= 1'b0;
            closeActive_q[i] <= 1'b0;
            cmdMs_q <= 16'h0000;
            openMs_q <= 16'h0000;
            closeMs_q <= 16'h0000;
            opCount_q[i] <= '0;
         end else begin
            reqOPrev_q <= unitIn[i].reqOpen;
            reqCPrev_q <= unitIn[i].reqClose;
            blkO_q <= unitIn[i].blkOpen; // [R1]
            blkC_q <= unitIn[i].blkClose; // [R1]
            oFail_q <= oFailNow; // [R18]
            cFail_q <= cFailNow; // [R18]
            openActive_q[i] <= oStart | (openActive_q[i] & ~oDone & ~tOut); // [R18]
            closeActive_q[i] <= cStart | (closeActive_q[i] & ~cDone & ~tOut); // [R18]
            cmdMs_q <= (oStart | cStart) ? 16'h0000 :
                       ((busy & msTick & (cmdMs_q != 16'hFFFF)) ? cmdMs_q + 16'h0001 : cmdMs_q);
            openMs_q <= oDone ? cmdMs_q : openMs_q; // [R7]
            closeMs_q <= cDone ? cmdMs_q : closeMs_q; // [R7]
            opCount_q[i].opens <= cntNext(opCount_q[i].opens, oDone, unitIn[i].cntClear); // [R4]
            opCount_q[i].closes <= cntNext(opCount_q[i].closes, cDone, unitIn[i].cntClear); // [R4]
            opCount_q[i].openFails <= cntNext(opCount_q[i].openFails, oFailNow, unitIn[i].cntClear); // [R4]
            opCount_q[i].closeFails <= cntNext(opCount_q[i].closeFails, cFailNow, unitIn[i].cntClear); // [R4]
         end
      end

      assign recReq[i] = oDone | cDone | oFailNow | cFailNow;
      always_comb begin
         recEnt[i].ts = msTime_q; // [R6]
         recEnt[i].unit = 4'(i);
         recEnt[i].kind = oDone ? KIND_OPEN_OK : (cDone ? KIND_CLOSE_OK :
                          (oFailNow ? KIND_OPEN_FAIL : KIND_CLOSE_FAIL));
         recEnt[i].openMs = oDone ? cmdMs_q : openMs_q; // [R7]
         recEnt[i].closeMs = cDone ? cmdMs_q : closeMs_q; // [R7]
         recEnt[i].state = unitState_q[i]; // [R8]
         recEnt[i].cart = cartState_q[i];
         recEnt[i].openFail = oFailNow ? oCause : FAIL_NONE;
         recEnt[i].closeFail = cFailNow ? cCause : FAIL_NONE;
         recEnt[i].openSrc = unitIn[i].openSrc;
         recEnt[i].closeSrc = unitIn[i].closeSrc;
         recEnt[i].general = {openActive_q[i], closeActive_q[i], blkO_q, blkC_q,
                              unitIn[i].ready, unitIn[i].sync, unitIn[i].finalTrip, unitIn[i].opTime};
      end

      // Level order follows the L_* positions, highest first [R5]
      assign lv[i*UNIT_NLV +: UNIT_NLV] = {unitIn[i].locXswi, unitIn[i].locXcbr, unitIn[i].opTime,
         unitIn[i].wear, unitIn[i].finalTrip, cFail_q, oFail_q, unitIn[i].sync, unitIn[i].ready,
         blkC_q & unitIn[i].reqClose, blkO_q & unitIn[i].reqOpen, closeActive_q[i], unitIn[i].reqClose,
         openActive_q[i], unitIn[i].reqOpen, 4'b0001 << cartState_q[i], 4'b0001 << unitState_q[i]};
   end

   // Indicators have no command path at all [R9] [R14]
   for (genvar k = 0; k < NIND; k++) begin : g_ind
      ssem_pos_decode u_ind (
         .clock, .nrst, .msTick, .useDelay(1'b0), .delayMs(16'h0000),
         .openIn(indOpenIn[k]), .closeIn(indCloseIn[k]), .state_q(indState_q[k])
      );
      assign lv[IND_BASE + k*IND_NLV +: IND_NLV] = 4'b0001 << indState_q[k]; // [R13]
   end

   // One pending event leaves per cycle, lowest source first
   logic hit;
   logic hitOn;
   logic [7:0] hitIdx;
   logic [NSRC-1:0] grantV;
   logic [NSRC-1:0] riseEv;
   logic [NSRC-1:0] fallEv;
   assign riseEv = lv & ~lvPrev_q & storeOn_q; // [R3]
   assign fallEv = ~lv & lvPrev_q & storeOff_q; // [R3]
   always_comb begin
      hit = 1'b0;
      hitOn = 1'b0;
      hitIdx = 8'h00;
      for (int s = NSRC - 1; s >= 0; s--) begin
         if (pendOn_q[s] | pendOff_q[s]) begin
            hit = 1'b1;
            hitOn = pendOn_q[s];
            hitIdx = 8'(s);
         end
      end
   end
   assign grantV = {{(NSRC-1){1'b0}}, hit} << hitIdx;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lvPrev_q <= '0;
         pendOn_q <= '0;
         pendOff_q <= '0;
         evtValid_q <= 1'b0;
         evt_q <= '0;
      end else begin
         lvPrev_q <= lv;
         // A new edge wins over the grant of the same bit
         pendOn_q <= (pendOn_q & ~(hitOn ? grantV : '0)) | riseEv; // [R3] [R5] [R13]
         pendOff_q <= (pendOff_q & ~(hitOn ? '0 : grantV)) | fallEv;
         evtValid_q <= hit;
         evt_q <= '{ts: msTime_q, src: hitIdx, isOn: hitOn}; // [R13]
      end
   end

   // Operation record ring; one record per cycle, lowest unit wins a tie
   ssem_rec_s recMem [NREC];
   logic [3:0] recWp_q;
   logic recHit;
   logic [3:0] recSel;
   logic [4:0] rdSum;
   logic [3:0] rdPos;
   always_comb begin
      recHit = 1'b0;
      recSel = 4'h0;
      for (int u = NUNIT - 1; u >= 0; u--) begin
         if (recReq[u]) begin
            recHit = 1'b1;
            recSel = 4'(u);
         end
      end
   end
   assign rdSum = {1'b0, recWp_q} + 5'(NREC - 1) - {1'b0, recRdIdx};
   assign rdPos = (rdSum >= 5'(NREC)) ? 4'(rdSum - 5'(NREC)) : rdSum[3:0];

   always_ff @(posedge clock) begin
      if (recHit) begin
         recMem[recWp_q] <= recEnt[recSel]; // [R6] [R8]
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         recWp_q <= 4'h0;
         recCount_q <= 4'h0;
         rec_q <= '0;
      end else begin
         if (recHit) begin
            recWp_q <= (recWp_q == 4'(NREC - 1)) ? 4'h0 : recWp_q + 4'h1; // [R19]
            recCount_q <= (recCount_q == 4'(NREC)) ? recCount_q : recCount_q + 4'h1; // [R6]
         end
         rec_q <= (recRdIdx < recCount_q) ? recMem[rdPos] : '0;
      end
   end

   // Indicator labels, written only during setup
   logic [7:0] labelMem [NIND*LABEL_CHARS];
   always_ff @(posedge clock) begin
      if (setupMode && labelWr && (labelInst < 3'(NIND))) begin
         labelMem[{labelInst, labelPos}] <= labelChar; // [R16] [R15]
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         labelRdChar_q <= 8'h00;
      end else begin
         labelRdChar_q <= (labelRdInst < 3'(NIND)) ? labelMem[{labelRdInst, labelRdPos}] : 8'h00; // [R16]
      end
   end
endmodule
`default_nettype wire

// ==== testbench/ssem_properties.sv ====
// Port assertions of the status monitor
`timescale 1ns/1ps
`default_nettype none
module ssem_properties
   import ssem_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [15:0] timeoutMsIn,
   input wire ssem_unit_in_s unitIn [NUNIT],
   input wire logic [NIND-1:0] indOpenIn,
   input wire logic [NIND-1:0] indCloseIn,
   input wire logic evtValid_q,
   input wire ssem_evt_s evt_q,
   input wire ssem_pos_e indState_q [NIND],
   input wire logic [NUNIT-1:0] openActive_q,
   input wire logic [NUNIT-1:0] closeActive_q,
   input wire ssem_cnt_s opCount_q [NUNIT],
   input wire logic [3:0] recCount_q,
   input wire logic [31:0] msTime_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   logic [31:0] gap_q;
   logic [31:0] act_q;
   logic seen_q;
   // Spacing is judged from the second tick on
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gap_q <= '0;
         act_q <= '0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= $changed(msTime_q) ? 32'h0 : gap_q + 32'h1;
         seen_q <= seen_q | $changed(msTime_q);
         act_q <= openActive_q[0] ? act_q + 32'h1 : 32'h0;
      end
   end
   for (genvar k = 0; k < NIND; k++) begin : g_ind
      a_ind_state_decode: assert property (1'b1 |=>
         2'(indState_q[k]) == {$past(indCloseIn[k]), $past(indOpenIn[k])})
         else $error("indicator state wrong");
   end
   a_open_starts: assert property ($rose(unitIn[0].reqOpen) && !unitIn[0].blkOpen &&
      !$past(unitIn[0].blkOpen) && !openActive_q[0] && !closeActive_q[0] |=> openActive_q[0])
      else $error("open did not start");
   a_open_blocked: assert property ($rose(unitIn[0].reqOpen) && unitIn[0].blkOpen &&
      $past(unitIn[0].blkOpen) && !openActive_q[0] |=> !openActive_q[0])
      else $error("blocked open request started");
   a_close_blocked: assert property ($rose(unitIn[0].reqClose) && unitIn[0].blkClose &&
      $past(unitIn[0].blkClose) && !closeActive_q[0] |=> !closeActive_q[0])
      else $error("blocked close request started");
   a_count_clear: assert property (unitIn[0].cntClear |=>
      opCount_q[0].opens <= 16'h0001 && opCount_q[0].closeFails <= 16'h0001)
      else $error("counters not cleared");
   a_rec_bound: assert property (recCount_q <= 4'(NREC))
      else $error("record count above twelve");
   a_rec_step: assert property (recCount_q != $past(recCount_q) |-> recCount_q == $past(recCount_q) + 4'h1)
      else $error("record count jumped");
   a_ms_step: assert property ($changed(msTime_q) |-> msTime_q == $past(msTime_q) + 32'h1)
      else $error("ms time jumped");
   a_ms_period: assert property (seen_q && $changed(msTime_q) |-> gap_q == 32'(MS_CYCLES - 1))
      else $error("ms tick spacing");
   a_cmd_timeout: assert property (act_q <= (32'(timeoutMsIn) + 32'h2) * 32'(MS_CYCLES))
      else $error("open outlived timeout");
   a_evt_source: assert property (evtValid_q |-> evt_q.src < 8'(NSRC))
      else $error("event source out of range");
endmodule
bind ssem_monitor ssem_properties #(.MS_CYCLES(MS_CYCLES)) u_props (.clock, .nrst, .timeoutMsIn, .unitIn,
   .indOpenIn, .indCloseIn, .evtValid_q, .evt_q, .indState_q, .openActive_q, .closeActive_q, .opCount_q,
   .recCount_q, .msTime_q);
`default_nettype wire

// ==== testbench/ssem_field_model.sv ====
// Contact model of one switchgear object
`timescale 1ns/1ps
`default_nettype none
module ssem_field_model #(
   parameter int MS_CYCLES = 10
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic openCmd,
   input wire logic closeCmd,
   input wire logic stuck,
   input wire logic [7:0] moveMs,
   output logic openSt,
   output logic closeSt
);
   logic [31:0] wait_q;
   // Both contacts drop, then the commanded one makes after moveMs
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         openSt <= 1'b0;
         closeSt <= 1'b1;
         wait_q <= '0;
      end else if (!stuck && (openCmd || closeCmd)) begin
         openSt <= 1'b0;
         closeSt <= 1'b0;
         wait_q <= wait_q + 32'h1;
         if (wait_q >= 32'(moveMs) * 32'(MS_CYCLES)) begin
            openSt <= openCmd;
            closeSt <= closeCmd;
         end
      end else begin
         wait_q <= '0;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/ssem_monitor_test.sv ====
// Self-checking bench of the switchgear status monitor
`timescale 1ns/1ps
`default_nettype none
module ssem_monitor_test
   import ssem_pkg::*;
;
   localparam int MSC = 10;
   logic clock, nrst, setupMode, labelWr, fOpen, fClose, stuck, checkOn;
   logic [15:0] traverseMsIn, timeoutMsIn;
   logic [NSRC-1:0] storeOnIn, storeOffIn, onM, offM;
   ssem_unit_in_s uDrv;
   wire ssem_unit_in_s unitIn [NUNIT];
   logic [NIND-1:0] indOpenIn, indCloseIn;
   logic [2:0] labelInst, labelRdInst;
   logic [4:0] labelPos, labelRdPos;
   logic [7:0] labelChar, labelRdChar_q, moveMs;
   logic [3:0] recRdIdx, recCount_q;
   logic evtValid_q;
   ssem_evt_s evt_q;
   ssem_pos_e unitState_q [NUNIT], cartState_q [NUNIT], indState_q [NIND];
   logic [NUNIT-1:0] openActive_q, closeActive_q;
   ssem_cnt_s opCount_q [NUNIT];
   ssem_rec_s rec_q;
   logic [31:0] msTime_q, seed, cycles;
   int error_cnt, check_count;
   logic [8:0] expQ [$];
   assign unitIn[0] = {fOpen, fClose, uDrv[17:0]};
   // Idle units cannot displace unit 0 records
   for (genvar i = 1; i < NUNIT; i++) begin : g_idle
      assign unitIn[i] = '0;
   end
   ssem_monitor #(.MS_CYCLES(MSC)) dut (.clock, .nrst, .setupMode, .traverseMsIn, .timeoutMsIn, .storeOnIn,
      .storeOffIn, .unitIn, .indOpenIn, .indCloseIn, .labelWr, .labelInst, .labelPos, .labelChar, .labelRdInst,
      .labelRdPos, .recRdIdx, .labelRdChar_q, .evtValid_q, .evt_q, .unitState_q, .cartState_q, .indState_q,
      .openActive_q, .closeActive_q, .opCount_q, .recCount_q, .rec_q, .msTime_q);
   ssem_field_model #(.MS_CYCLES(MSC)) field (.clock, .nrst, .openCmd(openActive_q[0]),
      .closeCmd(closeActive_q[0]), .stuck, .moveMs, .openSt(fOpen), .closeSt(fClose));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 32'h1;
      if (cycles == 32'd30000) begin
         error_cnt++;
         test_done();
      end
   end
   always @(negedge clock) begin
      if (nrst && checkOn && evtValid_q) begin
         if (expQ.size() == 0)
            chk("unexpected event", {evt_q.src, evt_q.isOn}, 32'h1FF);
         else
            chk("event", {evt_q.src, evt_q.isOn}, expQ.pop_front());
      end
   end
   // Queue the events of a contact change, then apply it
   task automatic ind(input int k, input logic o, input logic c);
      logic [1:0] old, nw;
      int b;
      old = {indCloseIn[k], indOpenIn[k]};
      nw = {c, o};
      b = IND_BASE + k * IND_NLV;
      for (int i = 0; i < 4; i++) begin
         if (old != nw && i == old && offM[b+i])
            expQ.push_back({8'(b + i), 1'b0});
         if (old != nw && i == nw && onM[b+i])
            expQ.push_back({8'(b + i), 1'b1});
      end
      indOpenIn[k] = o;
      indCloseIn[k] = c;
      repeat (10) @(negedge clock);
      chk("indicator state", 32'(indState_q[k]), 32'(nw));
   endtask
   task automatic cmd(input logic op, input logic [2:0] fail, input logic [1:0] kind);
      // A block just released is still registered for one edge
      @(negedge clock);
      uDrv.reqOpen = op;
      uDrv.reqClose = !op;
      repeat (3) @(negedge clock);
      for (int i = 0; i < 600 && (openActive_q[0] || closeActive_q[0]); i++)
         @(negedge clock);
      uDrv.reqOpen = 1'b0;
      uDrv.reqClose = 1'b0;
      recRdIdx = 4'h0;
      repeat (4) @(negedge clock);
      chk("record kind", 32'(rec_q.kind), 32'(kind));
      chk("record unit", 32'(rec_q.unit), 32'h0);
      chk("record cause", 32'(op ? rec_q.openFail : rec_q.closeFail), 32'(fail));
   endtask
   initial begin
      {nrst, labelWr, stuck, checkOn, uDrv, indOpenIn, indCloseIn} = '0;
      {labelInst, labelPos, labelChar, labelRdInst, labelRdPos, recRdIdx} = '0;
      setupMode = 1'b1;
      seed = 32'hC15AE1A5;
      cycles = '0;
      moveMs = 8'h03;
      traverseMsIn = 16'h0000;
      timeoutMsIn = 16'h0014;
      uDrv.ready = 1'b1;
      uDrv.sync = 1'b1;
      onM = '0;
      offM = '0;
      // Indicator 1 keeps ON edges only, indicator 2 OFF edges only
      for (int i = IND_BASE; i < NSRC; i++) begin
         onM[i] = (i - IND_BASE) / IND_NLV != 2;
         offM[i] = (i - IND_BASE) / IND_NLV != 1;
      end
      storeOnIn = onM;
      storeOffIn = offM;
      repeat (6) @(negedge clock);
      nrst = 1'b1;
      labelWr = 1'b1;
      labelInst = 3'h4;
      labelPos = 5'h1F;
      labelChar = 8'h5A;
      @(negedge clock);
      labelPos = 5'h00;
      labelChar = 8'h41;
      @(negedge clock);
      labelWr = 1'b0;
      repeat (600) @(negedge clock);
      setupMode = 1'b0;
      checkOn = 1'b1;
      storeOnIn = '1;
      storeOffIn = '1;
      labelWr = 1'b1;
      labelPos = 5'h1F;
      labelChar = 8'h00;
      @(negedge clock);
      labelWr = 1'b0;
      labelRdInst = 3'h4;
      repeat (2) @(negedge clock);
      chk("label start", 32'(labelRdChar_q), 32'h41);
      labelRdPos = 5'h1F;
      repeat (2) @(negedge clock);
      chk("label end", 32'(labelRdChar_q), 32'h5A);
      labelRdInst = 3'h5;
      repeat (2) @(negedge clock);
      chk("label none", 32'(labelRdChar_q), 32'h0);
      $display("test labels done");
      for (int n = 0; n < 40; n++) begin
         seed = xs(seed);
         ind(int'(seed % 5), seed[8], seed[9]);
      end
      repeat (20) @(negedge clock);
      chk("events left", expQ.size(), 32'h0);
      $display("test indicator events done");
      cmd(1'b1, FAIL_NONE, KIND_OPEN_OK);
      chk("open state", 32'(unitState_q[0]), 32'(POS_OPEN));
      chk("open time", 32'(rec_q.openMs >= 16'h3 && rec_q.openMs <= 16'h5), 32'h1);
      uDrv.blkClose = 1'b1;
      repeat (6 * MSC) @(negedge clock);
      cmd(1'b0, FAIL_BLOCKED, KIND_CLOSE_FAIL);
      uDrv.blkClose = 1'b0;
      uDrv.ready = 1'b0;
      cmd(1'b0, FAIL_NOTREADY, KIND_CLOSE_FAIL);
      uDrv.ready = 1'b1;
      uDrv.sync = 1'b0;
      cmd(1'b0, FAIL_NOSYNC, KIND_CLOSE_FAIL);
      uDrv.sync = 1'b1;
      stuck = 1'b1;
      cmd(1'b0, FAIL_TIMEOUT, KIND_CLOSE_FAIL);
      stuck = 1'b0;
      chk("close fails", 32'(opCount_q[0].closeFails), 32'h4);
      cmd(1'b0, FAIL_NONE, KIND_CLOSE_OK);
      uDrv.blkOpen = 1'b1;
      repeat (6 * MSC) @(negedge clock);
      cmd(1'b1, FAIL_BLOCKED, KIND_OPEN_FAIL);
      uDrv.blkOpen = 1'b0;
      for (int n = 0; n < 3; n++) begin
         cmd(1'b1, FAIL_NONE, KIND_OPEN_OK);
         cmd(1'b0, FAIL_NONE, KIND_CLOSE_OK);
      end
      chk("opens", 32'(opCount_q[0].opens), 32'h4);
      chk("record count", 32'(recCount_q), 32'(NREC));
      recRdIdx = 4'hB;
      repeat (2) @(negedge clock);
      chk("oldest cause", 32'(rec_q.closeFail), 32'(FAIL_BLOCKED));
      recRdIdx = 4'hC;
      repeat (2) @(negedge clock);
      chk("beyond records", 32'(rec_q.kind), 32'h0);
      $display("test commands done");
      uDrv.cntClear = 1'b1;
      @(negedge clock);
      uDrv.cntClear = 1'b0;
      @(negedge clock);
      chk("cleared opens", 32'(opCount_q[0].opens), 32'h0);
      $display("test counter clear done");
      test_done();
   end
endmodule
`default_nettype wire
